// *** gfa_fault_annunciator.sv ***
// gfa_fault_annunciator: warning and shutdown latching, lamps, stop and
// breaker-trip outputs, fault display feed and register port
// assumes condition, selector, switch and remote inputs come from pins
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module gfa_fault_annunciator #(
  parameter int unsigned FLASH_HALF_CYC = gfa_pkg::GFA_FLASH_HALF_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // monitored conditions and operator inputs
  input wire logic [gfa_pkg::GFA_NFAULT-1:0] faultCond,
  input wire logic [1:0] selector,
  input wire logic panelReset,
  input wire logic remoteStart,
  input wire logic remoteReset,
  input wire logic sleepReq,
  // lamps and set control
  output logic warnLamp,
  output logic shutLamp,
  output logic notAutoLamp,
  output logic stopCmd,
  output logic breakerTrip,
  output logic sleepGrant,
  // display feed
  output logic dispFaultOwn,
  output logic dispWrite,
  output logic [gfa_pkg::GFA_POS_W-1:0] dispPos,
  output logic [7:0] dispChar,
  output logic [11:0] dispCode,
  // register port
  input wire logic [gfa_pkg::GFA_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  output logic irq
);
  import gfa_pkg::*;

  localparam int unsigned NIN = GFA_NFAULT + 6;

  typedef struct packed {
    logic [GFA_NFAULT-1:0] warnLatch;
    logic [GFA_NFAULT-1:0] shutLatch;
    logic [GFA_NCUST-1:0] custClass;
    logic [GFA_IRQ_W-1:0] irqStat;
    logic [GFA_IRQ_W-1:0] irqMask;
    logic panelPrev;
    logic remRstPrev;
    logic remArmed;
    logic remStartOff;
    logic sleepPrev;
    logic [GFA_FLASH_CNT_W-1:0] flashCnt;
    logic flashPhase;
    logic [GFA_POS_W-1:0] scanPos;
    logic scanValid;
    logic [GFA_POS_W-1:0] posDly;
    logic writeDly;
    logic showOwn;
    logic [11:0] showCode;
    logic warnLamp;
    logic shutLamp;
    logic notAuto;
    logic sleepOk;
    logic [31:0] rdData;
  } gfa_state_t;

  gfa_state_t state_ff;
  gfa_state_t nxt_state;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [NIN-1:0] syncIn;
  logic [GFA_NFAULT-1:0] condS;
  logic [1:0] selS;
  logic panelS;
  logic remStartS;
  logic remRstS;
  logic sleepS;

  gfa_sync #(.WIDTH(NIN)) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .asyncIn({sleepReq, remoteReset, remoteStart, panelReset, selector, faultCond}),
    .syncOut(syncIn)
  );

  assign condS = syncIn[GFA_NFAULT-1:0];
  assign selS = syncIn[GFA_NFAULT+1:GFA_NFAULT];
  assign panelS = syncIn[GFA_NFAULT+2];
  assign remStartS = syncIn[GFA_NFAULT+3];
  assign remRstS = syncIn[GFA_NFAULT+4];
  assign sleepS = syncIn[GFA_NFAULT+5];

  // ----------------------------------------------------------------
  // display selection and message store
  // ----------------------------------------------------------------
  logic [GFA_IDX_W-1:0] showIdx;
  logic showShut;
  logic showAny;
  logic [7:0] romChar;

  always_comb begin
    showIdx = '0;
    showShut = 1'b0;
    showAny = 1'b0;
    // shutdowns take the display ahead of warnings, lowest index first
    for (int i = GFA_NFAULT - 1; i >= 0; i--) begin
      if (state_ff.warnLatch[i]) begin
        showIdx = GFA_IDX_W'(i);
        showAny = 1'b1;
      end
    end
    for (int i = GFA_NFAULT - 1; i >= 0; i--) begin
      if (state_ff.shutLatch[i]) begin
        showIdx = GFA_IDX_W'(i);
        showShut = 1'b1;
        showAny = 1'b1;
      end
    end
  end

  gfa_msg_rom u_rom (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .faultIdx(showIdx),
    .charPos(state_ff.scanPos),
    .shutClass(showShut),
    .msgChar(romChar)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [GFA_NFAULT-1:0] shutClassV;
    logic [GFA_NFAULT-1:0] warnClassV;
    logic [GFA_NFAULT-1:0] gone;
    logic [GFA_NFAULT-1:0] remShutMask;
    logic panelPress;
    logic remRise;
    logic remFall;
    logic remCycle;
    logic remShutOk;
    logic selOff;
    logic selAuto;
    logic flashTick;
    logic [GFA_IRQ_W-1:0] irqSet;
    logic [GFA_NFAULT-1:0] newWarn;
    logic [GFA_NFAULT-1:0] newShut;
    shutClassV = GFA_SHUT_FIXED | (GFA_NFAULT'(state_ff.custClass) << GFA_IDX_CUST0);
    warnClassV = ~shutClassV;
    gone = ~condS;
    remShutMask = ~(GFA_NFAULT'(1) << GFA_IDX_ESTOP);
    selOff = (selS != GFA_SEL_RUN) && (selS != GFA_SEL_AUTO);
    selAuto = (selS == GFA_SEL_AUTO);
    panelPress = panelS && !state_ff.panelPrev;
    remRise = remRstS && !state_ff.remRstPrev;
    remFall = !remRstS && state_ff.remRstPrev;
    irqSet = '0;
    nxt_state = state_ff;
    nxt_state.panelPrev = panelS;
    nxt_state.remRstPrev = remRstS;
    nxt_state.sleepPrev = sleepS;

    // remote reset cycle: assert then release; start must be off throughout for the shutdown clear
    if (remRise) begin
      nxt_state.remArmed = 1'b1;
      nxt_state.remStartOff = !remStartS;
    end else if (remRstS && remStartS) begin
      nxt_state.remStartOff = 1'b0;
    end
    remCycle = remFall && state_ff.remArmed;
    remShutOk = remCycle && selAuto && state_ff.remStartOff && !remStartS;
    if (remFall) begin
      nxt_state.remArmed = 1'b0;
      nxt_state.remStartOff = 1'b0;
    end

    // clears only touch entries whose condition has gone away
    if (panelPress) begin
      nxt_state.warnLatch = nxt_state.warnLatch & ~gone;
      if (selOff) begin
        nxt_state.shutLatch = nxt_state.shutLatch & ~gone;
      end
    end
    if (remCycle && selAuto) begin
      nxt_state.warnLatch = nxt_state.warnLatch & ~gone;
    end
    if (remShutOk) begin
      nxt_state.shutLatch = nxt_state.shutLatch & ~(gone & remShutMask);
    end

    // a live condition always sets, so it wins over any clear
    newWarn = condS & warnClassV & ~state_ff.warnLatch;
    newShut = condS & shutClassV & ~state_ff.shutLatch;
    nxt_state.warnLatch = nxt_state.warnLatch | (condS & warnClassV);
    nxt_state.shutLatch = nxt_state.shutLatch | (condS & shutClassV);
    irqSet[GFA_IRQ_NEWWARN] = |newWarn;
    irqSet[GFA_IRQ_NEWSHUT] = |newShut;
    irqSet[GFA_IRQ_CLEARED] = (|(state_ff.warnLatch | state_ff.shutLatch))
                              && !(|(nxt_state.warnLatch | nxt_state.shutLatch));

    // lamps and stop follow the latched state
    nxt_state.warnLamp = |nxt_state.warnLatch;
    nxt_state.shutLamp = |nxt_state.shutLatch;

    // sleep is withheld while anything is latched
    nxt_state.sleepOk = sleepS && !(|(nxt_state.warnLatch | nxt_state.shutLatch));
    irqSet[GFA_IRQ_SLEEPREF] = sleepS && !state_ff.sleepPrev && !nxt_state.sleepOk;

    // flash divider gives a one-cycle tick each half period
    flashTick = (state_ff.flashCnt == GFA_FLASH_CNT_W'(FLASH_HALF_CYC - 1));
    nxt_state.flashCnt = flashTick ? '0 : state_ff.flashCnt + 1'b1;
    if (flashTick) begin
      nxt_state.flashPhase = !state_ff.flashPhase;
    end
    nxt_state.notAuto = selOff ? nxt_state.flashPhase : !selAuto;

    // display scan over 2 x 16 positions while a fault owns the display
    nxt_state.showOwn = showAny;
    nxt_state.showCode = showAny ? GFA_CODE_BCD[showIdx] : 12'h000;
    nxt_state.scanValid = showAny;
    nxt_state.scanPos = showAny ? state_ff.scanPos + 1'b1 : '0;
    nxt_state.posDly = state_ff.scanPos;
    nxt_state.writeDly = state_ff.scanValid && showAny;

    // register port
    nxt_state.rdData = '0;
    if (regWr) begin
      case (regAddr)
        GFA_REG_CUSTCLS: begin
          nxt_state.custClass = regWrData[GFA_NCUST-1:0];
        end
        GFA_REG_IRQSTAT: begin
          nxt_state.irqStat = state_ff.irqStat & ~regWrData[GFA_IRQ_W-1:0];
        end
        GFA_REG_IRQMASK: begin
          nxt_state.irqMask = regWrData[GFA_IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    nxt_state.irqStat = nxt_state.irqStat | irqSet;
    if (regRd) begin
      case (regAddr)
        GFA_REG_STATUS: begin
          nxt_state.rdData = {state_ff.showCode, 10'h000, selS, 2'h0, state_ff.sleepOk,
                              state_ff.notAuto, state_ff.shutLamp, state_ff.shutLamp,
                              state_ff.shutLamp, state_ff.warnLamp};
        end
        GFA_REG_WARN: begin
          nxt_state.rdData = 32'(state_ff.warnLatch);
        end
        GFA_REG_SHUT: begin
          nxt_state.rdData = 32'(state_ff.shutLatch);
        end
        GFA_REG_CUSTCLS: begin
          nxt_state.rdData = 32'(state_ff.custClass);
        end
        GFA_REG_IRQSTAT: begin
          nxt_state.rdData = 32'(state_ff.irqStat);
        end
        GFA_REG_IRQMASK: begin
          nxt_state.rdData = 32'(state_ff.irqMask);
        end
        default: begin
          nxt_state.rdData = '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= '0;
      state_ff.custClass <= GFA_CUSTCLS_RST;
      state_ff.irqMask <= GFA_IRQMASK_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign warnLamp = state_ff.warnLamp;
  assign shutLamp = state_ff.shutLamp;
  assign notAutoLamp = state_ff.notAuto;
  assign stopCmd = state_ff.shutLamp;
  assign breakerTrip = state_ff.shutLamp;
  assign sleepGrant = state_ff.sleepOk;
  assign dispFaultOwn = state_ff.showOwn;
  assign dispWrite = state_ff.writeDly;
  assign dispPos = state_ff.posDly;
  assign dispChar = romChar;
  assign dispCode = state_ff.showCode;
  assign regRdData = state_ff.rdData;
  assign irq = |(state_ff.irqStat & state_ff.irqMask);

endmodule
`default_nettype wire

// *** gfa_fault_annunciator_properties.sv ***
// gfa_fault_annunciator_properties: port-level checks of the fault annunciator
// assumes it is bound to gfa_fault_annunciator and shares its flash parameter
`timescale 1ns/1ps
`default_nettype none
module gfa_fault_annunciator_properties #(
  parameter int unsigned FLASH_HALF_CYC = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // inputs watched
  input wire logic [gfa_pkg::GFA_NFAULT-1:0] faultCond,
  input wire logic [1:0] selector,
  input wire logic panelReset,
  input wire logic remoteReset,
  input wire logic regRd,
  // outputs watched
  input wire logic warnLamp,
  input wire logic shutLamp,
  input wire logic notAutoLamp,
  input wire logic stopCmd,
  input wire logic breakerTrip,
  input wire logic sleepGrant,
  input wire logic dispFaultOwn,
  input wire logic [31:0] regRdData
);
  import gfa_pkg::*;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // --------
  // flash watch: cycles the lamp has held still while the selector is off
  // --------
  logic [7:0] holdCnt_ff;
  logic lampSeen_ff;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      holdCnt_ff <= 8'h00;
      lampSeen_ff <= 1'b0;
    end else begin
      lampSeen_ff <= notAutoLamp;
      if (selector != 2'h0 || notAutoLamp != lampSeen_ff) begin
        holdCnt_ff <= 8'h00;
      end else begin
        holdCnt_ff <= holdCnt_ff + 8'h01;
      end
    end
  end

  // --------
  // assertions
  // --------
  stop_follows_shut_a: assert property (
    stopCmd == shutLamp && breakerTrip == shutLamp)
    else $error("stop or trip differs from shutdown lamp");
  shut_from_cond_a: assert property (
    ((faultCond & GFA_SHUT_FIXED) != '0) [*6] |-> shutLamp)
    else $error("shutdown condition without shutdown lamp");
  warn_from_cond_a: assert property (
    ((faultCond & ~(GFA_SHUT_FIXED | GFA_CUST_MASK)) != '0) [*6] |-> warnLamp)
    else $error("warning condition without warning lamp");
  shut_latched_a: assert property (
    (!panelReset && !remoteReset) [*6] ##0 shutLamp |=> shutLamp)
    else $error("shutdown dropped without a reset");
  run_keeps_shut_a: assert property (
    (selector == 2'h1) [*6] ##0 shutLamp |=> shutLamp)
    else $error("shutdown cleared outside off");
  off_flashes_a: assert property (holdCnt_ff <= FLASH_HALF_CYC + 6)
    else $error("not-in-auto lamp not flashing in off");
  auto_lamp_off_a: assert property ((selector == 2'h2) [*5] |-> !notAutoLamp)
    else $error("not-in-auto lamp lit in auto");
  sleep_refused_a: assert property (
    sleepGrant |-> !(warnLamp && $past(warnLamp)) && !(shutLamp && $past(shutLamp)))
    else $error("sleep granted with a fault latched");
  disp_taken_a: assert property ($rose(shutLamp) |=> dispFaultOwn)
    else $error("display not taken by shutdown");
  read_idle_zero_a: assert property (!regRd |=> regRdData == 32'h0)
    else $error("read data outside read answer");
endmodule

bind gfa_fault_annunciator gfa_fault_annunciator_properties #(
  .FLASH_HALF_CYC(FLASH_HALF_CYC)
) props (.sys_clk, .reset_n, .faultCond, .selector, .panelReset, .remoteReset, .regRd,
  .warnLamp, .shutLamp, .notAutoLamp, .stopCmd, .breakerTrip, .sleepGrant, .dispFaultOwn,
  .regRdData);
`default_nettype wire

// *** gfa_msg_rom.sv ***
// gfa_msg_rom: character store for the two-line fault display
// line 0 holds the message text, line 1 the code and its class
// assumes the caller holds faultIdx steady while scanning
`timescale 1ns/1ps
`default_nettype none
module gfa_msg_rom (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // lookup
  input wire logic [gfa_pkg::GFA_IDX_W-1:0] faultIdx,
  input wire logic [gfa_pkg::GFA_POS_W-1:0] charPos,
  input wire logic shutClass,
  output logic [7:0] msgChar
);
  import gfa_pkg::*;

  typedef struct packed {
    logic [7:0] charOut;
  } gfa_rom_state_t;

  gfa_rom_state_t state_ff;
  gfa_rom_state_t nxt_state;

  always_comb begin
    logic [11:0] bcd;
    logic [127:0] lineBits;
    logic [3:0] col;
    bcd = 12'h000;
    lineBits = '0;
    col = charPos[3:0];
    nxt_state = state_ff;
    if (faultIdx < GFA_IDX_W'(GFA_NFAULT)) begin
      bcd = GFA_CODE_BCD[faultIdx];
      if (!charPos[4]) begin
        lineBits = GFA_MSG_TEXT[faultIdx];
      end else begin
        lineBits = {4'h3, bcd[11:8], 4'h3, bcd[7:4], 4'h3, bcd[3:0], " - ",
                    (shutClass ? "SHUTDOWN  " : "WARNING   ")};
      end
    end else begin
      lineBits = "                ";
    end
    nxt_state.charOut = lineBits[127 - 8 * col -: 8];
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign msgChar = state_ff.charOut;

endmodule
`default_nettype wire

// *** gfa_panel_model.sv ***
// gfa_panel_model: operator selector, panel reset switch and remote inputs
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps
`default_nettype none
module gfa_panel_model (
  // clock
  input wire logic sys_clk,
  // panel and remote pins
  output logic [1:0] selector,
  output logic panelReset,
  output logic remoteStart,
  output logic remoteReset
);
  import gfa_pkg::*;

  initial begin
    selector = GFA_SEL_OFF;
    panelReset = 1'b0;
    remoteStart = 1'b0;
    remoteReset = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic set_sel(input gfa_sel_t s);
    @(posedge sys_clk);
    selector <= s;
    idle(4);
    #1;
  endtask

  task automatic set_start(input logic on);
    @(posedge sys_clk);
    remoteStart <= on;
    idle(4);
    #1;
  endtask

  // momentary switch, held long enough to pass the synchroniser
  task automatic press();
    @(posedge sys_clk);
    panelReset <= 1'b1;
    idle(3);
    panelReset <= 1'b0;
    idle(6);
    #1;
  endtask

  // dropStart removes remote start before the reset cycle begins
  task automatic remote_cycle(input logic dropStart);
    @(posedge sys_clk);
    if (dropStart) begin
      remoteStart <= 1'b0;
    end
    idle(3);
    remoteReset <= 1'b1;
    idle(3);
    remoteReset <= 1'b0;
    idle(6);
    #1;
  endtask
endmodule
`default_nettype wire

// *** gfa_pkg.sv ***
// gfa_pkg: constants shared by the generator-set fault annunciator files
// assumes a 20 MHz system clock and the fault index order listed below
package gfa_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned GFA_CLK_HZ = 20_000_000;
  localparam int unsigned GFA_FLASH_HALF_MS = 500;
  localparam int unsigned GFA_FLASH_HALF_CYC = (GFA_CLK_HZ / 1000) * GFA_FLASH_HALF_MS;
  localparam int unsigned GFA_FLASH_CNT_W = 24;

  // ----------------------------------------------------------------
  // fault table: index order 0..29
  // ----------------------------------------------------------------
  localparam int unsigned GFA_NFAULT = 30;
  localparam int unsigned GFA_IDX_W = 5;
  localparam int unsigned GFA_LINE_CHARS = 16;
  localparam int unsigned GFA_POS_W = 5;
  localparam int unsigned GFA_IDX_ESTOP = 1;
  localparam int unsigned GFA_IDX_CUST0 = 22;
  localparam int unsigned GFA_NCUST = 4;
  // fixed shutdown-class members; all other fixed entries are warnings
  localparam logic [29:0] GFA_SHUT_FIXED = 30'h1C087C8A;
  localparam logic [29:0] GFA_CUST_MASK = 30'h03C00000;

  localparam logic [11:0] GFA_CODE_BCD [0:29] = '{
    12'h101, 12'h102, 12'h200, 12'h201, 12'h204, 12'h210, 12'h211, 12'h212,
    12'h213, 12'h214, 12'h215, 12'h220, 12'h221, 12'h222, 12'h223, 12'h230,
    12'h231, 12'h232, 12'h240, 12'h250, 12'h251, 12'h252, 12'h260, 12'h261,
    12'h262, 12'h263, 12'h301, 12'h303, 12'h313, 12'h320};

  localparam logic [127:0] GFA_MSG_TEXT [0:29] = '{
    "IDLE MODE       ", "EMERGENCY STOP  ", "LOW OIL PRESSURE", "LOW OIL PRESSURE",
    "OIL PRES SENDER ", "LOW COOLANT TEMP", "HIGH COOLANT TMP", "HIGH COOLANT TMP",
    "COOLANT SENDER  ", "LOW COOLANT LVL ", "LOW COOLANT LVL ", "MAG PICKUP      ",
    "FAIL TO CRANK   ", "OVERCRANK       ", "OVERSPEED       ", "LOW DC VOLTAGE  ",
    "HIGH DC VOLTAGE ", "WEAK BATTERY    ", "LOW FUEL - DAY  ", "EEPROM ERROR    ",
    "EEPROM ERROR    ", "EEPROM ERROR    ", "CUSTOMER FAULT 1", "GROUND FAULT    ",
    "RUPTURE BASIN   ", "HIGH GEN TEMP   ", "HIGH AC VOLTAGE ", "LOW AC VOLTAGE  ",
    "UNDER FREQUENCY ", "OVERCURRENT     "};

  // ----------------------------------------------------------------
  // selector code on the two selector pins
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GFA_SEL_OFF = 2'h0,
    GFA_SEL_RUN = 2'h1,
    GFA_SEL_AUTO = 2'h2
  } gfa_sel_t;

  // ----------------------------------------------------------------
  // register map (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam int unsigned GFA_ADDR_W = 4;
  localparam logic [3:0] GFA_REG_STATUS = 4'h0;
  localparam logic [3:0] GFA_REG_WARN = 4'h1;
  localparam logic [3:0] GFA_REG_SHUT = 4'h2;
  localparam logic [3:0] GFA_REG_CUSTCLS = 4'h3;
  localparam logic [3:0] GFA_REG_IRQSTAT = 4'h4;
  localparam logic [3:0] GFA_REG_IRQMASK = 4'h5;
  localparam logic [3:0] GFA_CUSTCLS_RST = 4'h0;
  localparam logic [3:0] GFA_IRQMASK_RST = 4'h0;

  // interrupt status bit positions
  localparam int unsigned GFA_IRQ_W = 4;
  localparam int unsigned GFA_IRQ_NEWWARN = 0;
  localparam int unsigned GFA_IRQ_NEWSHUT = 1;
  localparam int unsigned GFA_IRQ_CLEARED = 2;
  localparam int unsigned GFA_IRQ_SLEEPREF = 3;

endpackage

// *** gfa_sync.sv ***
// gfa_sync: two flip-flop level synchroniser, one lane per bit
// assumes inputs are asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module gfa_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  import gfa_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } gfa_sync_state_t;

  gfa_sync_state_t state_ff;
  gfa_sync_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.stage1 = asyncIn;
    nxt_state.stage2 = state_ff.stage1;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign syncOut = state_ff.stage2;

endmodule
`default_nettype wire

// *** tb.sv ***
// tb: self-checking bench for the generator-set fault annunciator
// assumes the panel model drives the selector, switch and remote pins
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gfa_pkg::*;
  localparam int unsigned FLASH = 4;
  localparam int LIMIT = 20000;
  logic sys_clk, reset_n, sleepReq, regWr, regRd, panelReset, remoteStart, remoteReset;
  logic [29:0] faultCond;
  logic [3:0] regAddr;
  logic [31:0] regWrData, regRdData;
  logic [1:0] selector;
  logic warnLamp, shutLamp, notAutoLamp, stopCmd, breakerTrip, sleepGrant, irq;
  logic dispFaultOwn, dispWrite;
  logic [4:0] dispPos;
  logic [7:0] dispChar;
  logic [11:0] dispCode;
  int n_errors = 0, samples_checked = 0, cycles = 0;

  gfa_fault_annunciator #(.FLASH_HALF_CYC(FLASH)) dut (.sys_clk, .reset_n, .faultCond,
    .selector, .panelReset, .remoteStart, .remoteReset, .sleepReq, .warnLamp, .shutLamp,
    .notAutoLamp, .stopCmd, .breakerTrip, .sleepGrant, .dispFaultOwn, .dispWrite, .dispPos,
    .dispChar, .dispCode, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .irq);
  gfa_panel_model panel (.sys_clk, .selector, .panelReset, .remoteStart, .remoteReset);

  always #25 sys_clk = ~sys_clk;

  // --------
  // shared tasks
  // --------
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask

  task automatic wcyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask

  task automatic fault(input int i, input logic v);
    @(posedge sys_clk);
    faultCond[i] <= v;
    wcyc(6);
  endtask

  task automatic disp_char(input logic [4:0] pos, input logic [7:0] ch);
    int k;
    k = 0;
    while (!(dispWrite === 1'b1 && dispPos === pos) && k < 80) begin
      wcyc(1);
      k++;
    end
    chk(dispChar === ch && dispFaultOwn === 1'b1, "display character");
  endtask

  // --------
  // scenarios
  // --------
  task automatic t_regs();
    logic [31:0] d;
    reg_rd(GFA_REG_CUSTCLS, d);
    chk(d === {28'h0, GFA_CUSTCLS_RST}, "class register reset value");
    reg_rd(GFA_REG_IRQMASK, d);
    chk(d === {28'h0, GFA_IRQMASK_RST}, "mask register reset value");
    reg_wr(4'hF, 32'hFFFFFFFF);
    reg_rd(4'hF, d);
    chk(d === 32'h0, "unmapped read");
    reg_wr(GFA_REG_WARN, 32'h3FFFFFFF);
    reg_rd(GFA_REG_WARN, d);
    chk(d === 32'h0, "read-only write");
    $display("test regs done");
  endtask

  task automatic t_warn();
    reg_wr(GFA_REG_IRQMASK, 32'h1);
    @(posedge sys_clk);
    sleepReq <= 1'b1;
    fault(0, 1'b1);
    chk(warnLamp === 1'b1 && shutLamp === 1'b0 && dispCode === 12'h101, "warn");
    chk(irq === 1'b1, "irq raised");
    fault(0, 1'b0);
    chk(warnLamp === 1'b1 && sleepGrant === 1'b0, "sleep refused");
    panel.set_sel(GFA_SEL_RUN);
    panel.press();
    chk(warnLamp === 1'b0 && stopCmd === 1'b0 && sleepGrant === 1'b1, "run clear");
    reg_wr(GFA_REG_IRQMASK, 32'h0);
    wcyc(1);
    chk(irq === 1'b0, "irq masked");
    reg_wr(GFA_REG_IRQSTAT, 32'hF);
    reg_wr(GFA_REG_IRQMASK, 32'hF);
    wcyc(1);
    chk(irq === 1'b0, "irq cleared");
    @(posedge sys_clk);
    sleepReq <= 1'b0;
    $display("test warn done");
  endtask

  task automatic t_shut();
    int flips;
    logic prev;
    logic [31:0] d;
    fault(3, 1'b1);
    chk(shutLamp === 1'b1 && stopCmd === 1'b1 && breakerTrip === 1'b1, "stop");
    reg_rd(GFA_REG_STATUS, d);
    chk(d === {GFA_CODE_BCD[3], 10'h000, GFA_SEL_RUN, 2'h0, 6'h1E}, "status word");
    fault(3, 1'b0);
    panel.press();
    chk(shutLamp === 1'b1 && dispCode === 12'h201, "kept in run");
    panel.set_sel(GFA_SEL_OFF);
    flips = 0;
    prev = notAutoLamp;
    repeat (20) begin
      wcyc(1);
      if (notAutoLamp !== prev) flips++;
      prev = notAutoLamp;
    end
    chk(flips >= 4, "flashing in off");
    panel.press();
    chk(shutLamp === 1'b0 && stopCmd === 1'b0 && breakerTrip === 1'b0, "off clear");
    $display("test shut done");
  endtask

  task automatic t_remote();
    logic [31:0] d;
    panel.set_sel(GFA_SEL_AUTO);
    panel.set_start(1'b1);
    @(posedge sys_clk);
    faultCond <= 30'h0000000B;
    wcyc(6);
    @(posedge sys_clk);
    faultCond <= 30'h0;
    wcyc(6);
    panel.remote_cycle(1'b0);
    reg_rd(GFA_REG_SHUT, d);
    chk(d === 32'hA && warnLamp === 1'b0, "start held");
    panel.remote_cycle(1'b1);
    reg_rd(GFA_REG_SHUT, d);
    chk(d === 32'h2 && shutLamp === 1'b1 && dispCode === 12'h102, "stop kept");
    panel.set_sel(GFA_SEL_OFF);
    panel.press();
    chk(shutLamp === 1'b0, "panel clears emergency stop");
    $display("test remote done");
  endtask

  task automatic t_classes();
    logic [31:0] d;
    logic sh;
    for (int p = 0; p < 2; p++) begin
      reg_wr(GFA_REG_CUSTCLS, p ? 32'hF : 32'h0);
      for (int i = 0; i < GFA_NFAULT; i++) begin
        if (p == 1 && !GFA_CUST_MASK[i]) continue;
        sh = GFA_SHUT_FIXED[i] | (p == 1);
        fault(i, 1'b1);
        chk(shutLamp === sh && warnLamp === !sh, "lamp class");
        reg_rd(sh ? GFA_REG_SHUT : GFA_REG_WARN, d);
        chk(d === (32'h1 << i) && dispCode === GFA_CODE_BCD[i], "latch");
        disp_char(5'h00, GFA_MSG_TEXT[i][127:120]);
        disp_char(5'h10, 8'h30 + GFA_CODE_BCD[i][11:8]);
        disp_char(5'h16, sh ? "S" : "W");
        fault(i, 1'b0);
        panel.press();
        chk(warnLamp === 1'b0 && shutLamp === 1'b0, "class clear");
      end
    end
    $display("test classes done");
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    faultCond = '0;
    sleepReq = 1'b0;
    regAddr = '0;
    regWrData = '0;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    wcyc(2);
    t_regs();
    t_warn();
    t_shut();
    t_remote();
    t_classes();
    give_verdict();
  end
endmodule
`default_nettype wire
